// file: dmc_host.sv
// Controller model: free-running DDR clock, command pins, write bursts.
// Assumes clk is the 10 MHz system clock of the bench.
`default_nettype none
module dmc_host
    import dmc_pkg::*;
(
    // System clock
    input wire logic clk,
    // DDR side
    output var logic ck,
    output var dmc_cmd_s cmd,
    output var logic [DW-1:0] dq,
    output var logic [DW/8-1:0] dm,
    output var logic dqs
);
    timeunit 1ns;
    timeprecision 1ns;
    dmc_cmd_s nxt;
    logic pend;
    // ------------------------------------------------
    // Clock
    // ------------------------------------------------
    // Odd offset keeps CK edges away from clk edges
    initial begin
        ck = 1'b0;
        #37;
        forever #400 ck = ~ck;
    end
    // ------------------------------------------------
    // Drivers
    // ------------------------------------------------
    initial begin
        cmd = '1;
        pend = 1'b0;
        dq = '0;
        dm = '0;
        dqs = 1'b0;
    end
    // Pins move just after a CK fall, so they stand 3+ clk around a rise
    always @(negedge ck) begin
        @(negedge clk);
        if (pend) begin
            cmd = nxt;
        end else begin
            cmd.cs_n = 1'b1;
            cmd.ba = ~cmd.ba;
            cmd.a = ~cmd.a;
        end
        pend = 1'b0;
    end
    // Returns at the CK rise that carries the command
    task automatic issue(input dmc_cmd_s c);
        @(posedge clk);
        nxt = c;
        pend = 1'b1;
        wait (!pend);
        @(posedge ck);
    endtask
    // Data centred on each strobe edge; bus inverted after a fall
    task automatic put_beat(input logic [DW-1:0] d);
        @(negedge clk);
        dq = d;
        repeat (4) @(negedge clk);
        dqs = ~dqs;
        repeat (4) @(negedge clk);
        if (!dqs) dq = ~dq;
    endtask
endmodule // dmc_host
`default_nettype wire

// file: dmc_pkg.sv
// Shared constants and types for the DDR module command, data and
// presence-detect logic. Assumes one 10 MHz system clock.
`default_nettype none
package dmc_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int AW = 13;
    localparam int DW = 32;
    localparam int NBANK = 4;
    localparam int COL_W = 10;
    localparam int AP_BIT = 10;
    // ------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam int MR_CL_LSB = 4;
    localparam int MR_DLL_BIT = 8;
    localparam logic [AW-1:0] MR_RESET = 13'h0022;
    localparam logic [2:0] BL2 = 3'h1;
    localparam logic [2:0] BL4 = 3'h2;
    localparam logic [2:0] BL8 = 3'h3;
    localparam logic [2:0] CL20 = 3'h2;
    localparam logic [2:0] CL25 = 3'h6;
    localparam logic [3:0] CL20_HALF = 4'h4;
    localparam logic [3:0] CL25_HALF = 4'h5;
    // ------------------------------------------------------------
    // Presence-detect store
    // ------------------------------------------------------------
    localparam int SPD_BYTES = 256;
    localparam logic [3:0] SPD_DEV_HI = 4'ha;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_MRS = 4'h0,
        CMD_REF = 4'h1,
        CMD_PRE = 4'h2,
        CMD_ACT = 4'h3,
        CMD_WR  = 4'h4,
        CMD_RD  = 4'h5,
        CMD_BST = 4'h6,
        CMD_NOP = 4'h7
    } dmc_cmd_e;
    typedef enum logic [2:0] {
        SP_IDLE = 3'h0,
        SP_DEV  = 3'h1,
        SP_WORD = 3'h2,
        SP_WDAT = 3'h3,
        SP_RDAT = 3'h4
    } dmc_spd_e;
    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] ba;
        logic [AW-1:0] a;
    } dmc_cmd_s;
    typedef struct packed {
        logic ck;
        logic ck_n;
        logic dqs;
        logic [DW/8-1:0] dm;
        logic [DW-1:0] dq;
    } dmc_lnk_s;
endpackage
`default_nettype wire

// file: dmc_spd.sv
// Presence-detect store with its two-wire slave port.
// Assumes SCL, SDA and straps are asynchronous pins.
`default_nettype none
module dmc_spd
    import dmc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Two-wire pins
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Configuration
    input wire logic [2:0] straps,
    input wire logic maker_we
);
    logic [2:0] scl_m, sda_m;
    logic scl_s, sda_s, scl_q, sda_q;
    logic [3:0] str_m, str_s;
    dmc_spd_e st_r;
    logic ack_r, rw_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r, ptr_r;
    // Nonvolatile: never reset
    logic [7:0] mem [SPD_BYTES];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_m <= 3'h7;
            sda_m <= 3'h7;
            str_m <= 4'h0;
            str_s <= 4'h0;
        end else begin
            scl_m <= {scl_m[1:0], scl};
            sda_m <= {sda_m[1:0], sda_i};
            str_m <= {maker_we, straps};
            str_s <= str_m;
        end
    end
    assign scl_s = scl_m[1];
    assign sda_s = sda_m[1];
    assign scl_q = scl_m[2];
    assign sda_q = sda_m[2];

    wire start = scl_s & scl_q & sda_q & ~sda_s;
    wire stop = scl_s & scl_q & ~sda_q & sda_s;
    wire scl_rise = scl_s & ~scl_q;
    wire scl_fall = ~scl_s & scl_q;
    wire [7:0] rd_byte = mem[ptr_r];
    wire dev_hit = sh_r[7:1] == {SPD_DEV_HI, str_s[2:0]}; // R19
    // Maker area is locked unless the maker strobe is high
    wire wr_ok = ptr_r[7] | str_s[3]; // R18

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= SP_IDLE;
            ack_r <= 1'b0;
            rw_r <= 1'b0;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            ptr_r <= 8'h00;
            sda_oe <= 1'b0;
            sda_o <= 1'b0;
        end else if (start) begin
            st_r <= SP_DEV;
            ack_r <= 1'b0;
            cnt_r <= 4'h0;
            sda_oe <= 1'b0;
        end else if (stop) begin
            st_r <= SP_IDLE;
            sda_oe <= 1'b0;
        end else if (scl_rise && st_r != SP_IDLE) begin
            if (!ack_r && st_r != SP_RDAT) begin
                sh_r <= {sh_r[6:0], sda_s};
                cnt_r <= cnt_r + 4'h1;
            end else if (ack_r && st_r == SP_RDAT) begin
                if (sda_s) st_r <= SP_IDLE;
                ptr_r <= ptr_r + 8'h01;
            end
        end else if (scl_fall && st_r != SP_IDLE) begin
            if (ack_r) begin
                ack_r <= 1'b0;
                cnt_r <= 4'h0;
                sda_oe <= 1'b0;
                if ((st_r == SP_DEV && rw_r) || st_r == SP_RDAT) begin
                    st_r <= SP_RDAT;
                    sda_oe <= ~rd_byte[7]; // R20
                    cnt_r <= 4'h1;
                end else if (st_r == SP_DEV) begin
                    st_r <= SP_WORD;
                end else begin
                    st_r <= SP_WDAT;
                end
            end else if (st_r == SP_RDAT) begin
                if (cnt_r == 4'h8) begin
                    sda_oe <= 1'b0;
                    ack_r <= 1'b1;
                end else begin
                    sda_oe <= ~rd_byte[3'(4'h7 - cnt_r)];
                    cnt_r <= cnt_r + 4'h1;
                end
            end else if (cnt_r == 4'h8) begin
                ack_r <= 1'b1;
                sda_oe <= 1'b1;
                unique case (st_r)
                    SP_DEV: begin
                        rw_r <= sh_r[0];
                        if (!dev_hit) begin
                            st_r <= SP_IDLE;
                            sda_oe <= 1'b0;
                        end
                    end
                    SP_WORD: ptr_r <= sh_r;
                    SP_WDAT: ptr_r <= ptr_r + 8'h01;
                    default: sda_oe <= 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (scl_fall && !ack_r && cnt_r == 4'h8 &&
            st_r == SP_WDAT && wr_ok) begin
            mem[ptr_r] <= sh_r; // R17
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_spd_idle_quiet: assert property (@(posedge clk) disable iff
        (!rst_n) st_r == SP_IDLE |=> !sda_oe) // R20
        else $error("SDA driven while idle");
    cov_spd_read: cover property (@(posedge clk) disable iff (!rst_n)
        st_r == SP_RDAT && sda_oe);
endmodule // dmc_spd
`default_nettype wire

// file: dmc_tb.sv
// Self-checking bench for dmc_top: mode register, banks, bursts, store.
// Assumes dmc_host plays the controller on the DDR side.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import dmc_pkg::*;
    // ------------------------------------------------
    // Signals
    // ------------------------------------------------
    localparam logic [7:0] DEV = {SPD_DEV_HI, 3'h5, 1'b0};
    logic clk = 1'b0, rst_n, ck, dqs_h, dq_oe, dqs_o, dqs_oe, wr_act, rd_act;
    logic scl, sda_m, sda_oe, sda_o, maker_we;
    logic [DW-1:0] dq_h, dq_o;
    logic [DW/8-1:0] dm;
    logic [AW-1:0] mode;
    logic [NBANK-1:0] open_b;
    dmc_cmd_s cmd;
    int failures = 0;
    int n_tests = 0;
    wire logic sda_w = sda_m & ~sda_oe;
    dmc_host host (.clk(clk), .ck(ck), .cmd(cmd), .dq(dq_h), .dm(dm),
        .dqs(dqs_h));
    // Shared wires: an enabled driver wins, else the host's level
    dmc_top DUT (.REF_CLK(clk), .RST_N(rst_n), .CK(ck),
        .CK_N(~ck),
        .CKE(cmd.cke), .CS_N(cmd.cs_n), .RAS_N(cmd.ras_n),
        .CAS_N(cmd.cas_n), .WE_N(cmd.we_n), .BA(cmd.ba), .A(cmd.a),
        .DQ_I(dq_oe ? dq_o : dq_h), .DQ_O(dq_o), .DQ_OE(dq_oe),
        .DM(dm), .DQS_I(dqs_oe ? dqs_o : dqs_h), .DQS_O(dqs_o),
        .DQS_OE(dqs_oe), .MODE_REG(mode), .BANK_OPEN(open_b),
        .READ_ACTIVE(rd_act), .WRITE_ACTIVE(wr_act), .SPD_SCL(scl),
        .SPD_SDA_I(sda_w), .SPD_SDA_O(sda_o), .SPD_SDA_OE(sda_oe),
        .SPD_SLAVE_ADDRESS_STRAPS(3'h5), .SPD_MAKER_WE(maker_we));
    // ------------------------------------------------
    // Helpers
    // ------------------------------------------------
    task automatic compare(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    function automatic dmc_cmd_s mk(input logic [2:0] op,
        input logic [1:0] b, input logic [AW-1:0] a);
        return '{1'b1, 1'b0, op[2], op[1], op[0], b, a};
    endfunction
    function automatic logic [DW-1:0] wdat(input logic [3:0] c);
        return {28'hc0de000, c};
    endfunction
    // Counts CK edges to the first beat, then checks every beat
    task automatic rd_check(input logic [1:0] b, input logic [3:0] col,
        input logic ap, input int n, input int cl, input logic il);
        logic [3:0] cc;
        logic prv;
        int e;
        e = 0;
        host.issue(mk(3'h5, b, {2'h0, ap, 6'h00, col}));
        prv = ck;
        for (int k = 0; k < 40 && dq_oe !== 1'b1; k++) begin
            @(negedge clk);
            if (ck !== prv) e++;
            prv = ck;
        end
        compare("latency", cl, e);
        compare("read busy", 1, rd_act);
        tick(2);
        for (int i = 0; i < n; i++) begin
            cc = il ? col ^ 4'(i) :
                (col & ~4'(n - 1)) | (4'(col + i) & 4'(n - 1));
            compare("read word", wdat(cc), dq_o);
            compare("read strobe", {31'h0, ~i[0]}, dqs_o);
            tick(4);
        end
        compare("strobe off", 0, {dq_oe, dqs_oe, rd_act});
    endtask
    task automatic i2c_bit(input logic b, output logic r);
        tick(4);
        sda_m = b;
        tick(4);
        scl = 1'b1;
        tick(4);
        r = sda_w;
        tick(4);
        scl = 1'b0;
    endtask
    task automatic i2c_start;
        tick(8);
        sda_m = 1'b1;
        tick(8);
        scl = 1'b1;
        tick(8);
        sda_m = 1'b0;
        tick(8);
        scl = 1'b0;
    endtask
    task automatic i2c_stop;
        tick(8);
        sda_m = 1'b0;
        tick(8);
        scl = 1'b1;
        tick(8);
        sda_m = 1'b1;
    endtask
    task automatic i2c_byte(input logic [7:0] b, input logic mack,
        output logic [8:0] r);
        for (int i = 7; i >= 0; i--)
            i2c_bit(b[i], r[i + 1]);
        i2c_bit(mack, r[0]);
    endtask
    task automatic spd_wr(input logic [7:0] a, input logic [7:0] d);
        logic [8:0] r;
        i2c_start;
        i2c_byte(DEV, 1'b1, r);
        compare("spd ack", 0, r[0]);
        i2c_byte(a, 1'b1, r);
        i2c_byte(d, 1'b1, r);
        i2c_stop;
    endtask
    task automatic spd_rd(input logic [7:0] a, output logic [7:0] q);
        logic [8:0] r;
        i2c_start;
        i2c_byte(DEV, 1'b1, r);
        i2c_byte(a, 1'b1, r);
        i2c_start;
        i2c_byte(DEV | 8'h01, 1'b1, r);
        i2c_byte(8'hff, 1'b1, r);
        i2c_stop;
        q = r[8:1];
    endtask
    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic t_reset;
        compare("mode reset", 13'h0022, mode);
        compare("banks reset", 0, open_b);
        compare("drivers reset", 0, {dq_oe, dqs_oe, sda_oe, sda_o});
    endtask
    task automatic t_mode;
        dmc_cmd_s c;
        c = mk(3'h0, 2'h0, 13'h0041);
        c.cs_n = 1'b1;
        host.issue(c);
        tick(6);
        compare("masked load", 13'h0022, mode);
        host.issue(mk(3'h0, 2'h1, 13'h0041));
        tick(6);
        compare("extended load", 13'h0022, mode);
        host.issue(mk(3'h0, 2'h0, 13'h016b));
        tick(6);
        compare("mode load", 13'h006b, mode);
    endtask
    task automatic t_act;
        host.issue(mk(3'h3, 2'h1, 13'h0ffe));
        host.issue(mk(3'h3, 2'h2, 13'h0ffe));
        tick(6);
        compare("banks open", 4'h6, open_b);
    endtask
    task automatic t_write;
        host.issue(mk(3'h4, 2'h1, 13'h0000));
        for (int i = 0; i < 8; i++) begin
            host.put_beat(wdat(4'(i)));
            if (i == 0) compare("write busy", 1, wr_act);
        end
        tick(4);
        compare("write done", 0, wr_act);
    endtask
    task automatic t_read_ap;
        rd_check(2'h1, 4'h5, 1'b1, 8, 5, 1'b1);
        tick(8);
        compare("auto close", 4'h4, open_b);
    endtask
    task automatic t_reload;
        host.issue(mk(3'h2, 2'h0, 13'h0400));
        tick(6);
        compare("close all", 0, open_b);
        host.issue(mk(3'h0, 2'h0, 13'h0022));
        tick(6);
        compare("reload", 13'h0022, mode);
        host.issue(mk(3'h3, 2'h1, 13'h0ffe));
        rd_check(2'h1, 4'h6, 1'b1, 4, 4, 1'b0);
        host.issue(mk(3'h0, 2'h0, 13'h0021));
        host.issue(mk(3'h3, 2'h1, 13'h0ffe));
        rd_check(2'h1, 4'h3, 1'b0, 2, 4, 1'b0);
    endtask
    task automatic t_spd;
        logic [8:0] r;
        logic [7:0] q;
        i2c_start;
        i2c_byte({SPD_DEV_HI, 4'h0}, 1'b1, r);
        i2c_stop;
        compare("wrong address", 1, r[0]);
        maker_we = 1'b1;
        spd_wr(8'h00, 8'h11);
        maker_we = 1'b0;
        spd_wr(8'h00, 8'h22);
        spd_wr(8'hff, 8'h3c);
        spd_rd(8'h00, q);
        compare("maker byte", 8'h11, q);
        spd_rd(8'hff, q);
        compare("user byte", 8'h3c, q);
    endtask
    // ------------------------------------------------
    // Run
    // ------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        rst_n = 1'b0;
        scl = 1'b1;
        sda_m = 1'b1;
        maker_we = 1'b0;
        tick(4);
        rst_n = 1'b1;
        t_reset;
        t_mode;
        t_act;
        t_write;
        t_read_ap;
        t_reload;
        t_spd;
        summarize;
    end
    // About six times the expected run length
    initial begin
        tick(20000);
        failures++;
        summarize;
    end
endmodule // testbench
`default_nettype wire

// file: dmc_top.sv
// DDR module command decode, mode register, banks, burst data path
// and presence-detect store. All pins are sampled by REF_CLK.
//
// Notes on behaviour
// [R1] Commands taken only on clock rising edges
// [R2] Rising edge: true clock up, complement low
// [R3] Write data caught on both strobe edges
// [R4] Strobe driven only while read data flows
// [R5] Double-width fetch, two half-clock beats
// [R6] Controller activates a row before access
// [R7] Activate: bank from BA, row from A
// [R8] Access: bank from BA, column A0-A9
// [R9] Burst length two, four or eight
// [R10] Auto precharge closes bank at burst end
// [R11] Four banks with independent open state
// [R12] Mode load when both bank lines low
// [R13] Mode bit A8 clears itself after write
// [R14] Mode reload never touches array contents
// [R15] Controller loads mode only when idle
// [R16] Mode fields: length, type, latency, mode
// [R17] Presence store holds 256 bytes
// [R18] Lower half maker data, upper half user
// [R19] Three straps pick one of eight addresses
// [R20] Serial clock input, serial data two-way
// [R21] Chip select high masks the command
// [R22] A10 requests auto precharge on access
// [R23] Controller keeps clock enable high in bursts
// [R24] Burst wraps inside its aligned block
// [R25] Controller tracks open rows and delays
`default_nettype none
module dmc_top
    import dmc_pkg::*;
#(
    parameter int ROW_W = 12,
    parameter int ROW_IDX = 1,
    parameter int MEM_COL_W = 4
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Command pins
    input wire logic CK,
    input wire logic CK_N,
    input wire logic CKE,
    input wire logic CS_N,
    input wire logic RAS_N,
    input wire logic CAS_N,
    input wire logic WE_N,
    input wire logic [1:0] BA,
    input wire logic [AW-1:0] A,
    // Data pins
    input wire logic [DW-1:0] DQ_I,
    output logic [DW-1:0] DQ_O,
    output logic DQ_OE,
    input wire logic [DW/8-1:0] DM,
    input wire logic DQS_I,
    output logic DQS_O,
    output logic DQS_OE,
    // Status
    output logic [AW-1:0] MODE_REG,
    output logic [NBANK-1:0] BANK_OPEN,
    output logic READ_ACTIVE,
    output logic WRITE_ACTIVE,
    // Presence detect
    input wire logic SPD_SCL,
    input wire logic SPD_SDA_I,
    output logic SPD_SDA_O,
    output logic SPD_SDA_OE,
    input wire logic [2:0] SPD_SLAVE_ADDRESS_STRAPS,
    input wire logic SPD_MAKER_WE
);
    localparam int IW = 2 + ROW_IDX + MEM_COL_W;
    localparam int MEM_N = 1 << IW;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    dmc_cmd_s cmd_m, cmd_r;
    dmc_lnk_s lnk_m, lnk_r;
    logic ck_q, dqs_q;

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            cmd_m <= '1;
            cmd_r <= '1;
            lnk_m <= '0;
            lnk_r <= '0;
            ck_q <= 1'b0;
            dqs_q <= 1'b0;
        end else begin
            cmd_m <= {CKE, CS_N, RAS_N, CAS_N, WE_N, BA, A};
            cmd_r <= cmd_m;
            lnk_m <= {CK, CK_N, DQS_I, DM, DQ_I};
            lnk_r <= lnk_m;
            ck_q <= lnk_r.ck;
            dqs_q <= lnk_r.dqs;
        end
    end

    // ------------------------------------------------------------
    // Edge detect and command decode
    // ------------------------------------------------------------
    wire ck_rise = lnk_r.ck & ~lnk_r.ck_n & ~ck_q; // R2
    wire ck_fall = ~lnk_r.ck & ck_q;
    wire ck_edge = ck_rise | ck_fall;
    wire dqs_edge = lnk_r.dqs ^ dqs_q;
    wire cmd_ok = ck_rise & cmd_r.cke & ~cmd_r.cs_n; // R1 R21
    wire [3:0] code = {cmd_r.cs_n, cmd_r.ras_n, cmd_r.cas_n,
        cmd_r.we_n};
    wire is_mrs = cmd_ok && code == CMD_MRS && cmd_r.ba == 2'h0; // R12
    wire is_act = cmd_ok && code == CMD_ACT;
    wire is_pre = cmd_ok && code == CMD_PRE;
    wire is_rd = cmd_ok && code == CMD_RD;
    wire is_wr = cmd_ok && code == CMD_WR;

    // ------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------
    logic [AW-1:0] mode_r;
    wire [2:0] bl_code = mode_r[MR_BL_LSB+:3]; // R16
    wire [2:0] cl_code = mode_r[MR_CL_LSB+:3];
    // Reserved length codes fall back to two beats
    wire [3:0] bl_len = bl_code == BL8 ? 4'h8 :
        bl_code == BL4 ? 4'h4 : 4'h2; // R9
    wire [2:0] bl_msk = 3'(bl_len - 4'h1);
    // Reserved latency codes behave as two clocks
    wire [3:0] cl_half = cl_code == CL25 ? CL25_HALF : CL20_HALF;

    // Loading only rewrites this register; the array is not touched
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            mode_r <= MR_RESET;
        end else if (is_mrs) begin
            mode_r <= cmd_r.a; // R12 R14
        end else if (mode_r[MR_DLL_BIT]) begin
            mode_r[MR_DLL_BIT] <= 1'b0; // R13
        end
    end
    assign MODE_REG = mode_r;

    // ------------------------------------------------------------
    // Burst engine
    // ------------------------------------------------------------
    logic bur_rd_r, bur_wr_r, bur_ap_r, bur_bt_r;
    logic [1:0] bur_ba_r;
    logic [ROW_IDX-1:0] bur_row_r;
    logic [COL_W-1:0] bur_col_r;
    logic [2:0] bur_msk_r, beat_r;
    logic [3:0] left_r, lat_r;
    logic [ROW_IDX-1:0] row_lsb [NBANK];

    wire beat_go = bur_rd_r & ck_edge & (lat_r <= 4'h1);
    wire wr_go = bur_wr_r & dqs_edge; // R3
    wire step = beat_go | wr_go;
    wire last = step & (left_r == 4'h1);
    wire ap_fire = last & bur_ap_r; // R10

    // Beat order inside the aligned block
    wire [2:0] st = bur_col_r[2:0];
    wire [2:0] beat1 = 3'(beat_r + 3'h1);
    wire [2:0] off0 = bur_bt_r ? (st ^ beat_r) : 3'(st + beat_r);
    wire [2:0] off1 = bur_bt_r ? (st ^ beat1) : 3'(st + beat1);
    wire [2:0] lo0 = (st & ~bur_msk_r) | (off0 & bur_msk_r); // R24
    wire [2:0] lo1 = (st & ~bur_msk_r) | (off1 & bur_msk_r);
    wire [MEM_COL_W-4:0] col_hi = bur_col_r[MEM_COL_W-1:3];
    wire [IW-1:0] idx0 = {bur_ba_r, bur_row_r, col_hi, lo0};
    wire [IW-1:0] idx1 = {bur_ba_r, bur_row_r, col_hi, lo1};

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            bur_rd_r <= 1'b0;
            bur_wr_r <= 1'b0;
            bur_ap_r <= 1'b0;
            bur_bt_r <= 1'b0;
            bur_ba_r <= 2'h0;
            bur_row_r <= '0;
            bur_col_r <= '0;
            bur_msk_r <= 3'h0;
            beat_r <= 3'h0;
            left_r <= 4'h0;
            lat_r <= 4'h0;
        end else if (is_rd || is_wr) begin
            bur_rd_r <= is_rd;
            bur_wr_r <= is_wr;
            bur_ba_r <= cmd_r.ba; // R8
            bur_row_r <= row_lsb[cmd_r.ba];
            bur_col_r <= cmd_r.a[COL_W-1:0]; // R8
            bur_ap_r <= cmd_r.a[AP_BIT]; // R22
            bur_bt_r <= mode_r[MR_BT_BIT];
            bur_msk_r <= bl_msk;
            beat_r <= 3'h0;
            left_r <= bl_len; // R9
            lat_r <= cl_half;
        end else begin
            if (bur_rd_r && ck_edge && lat_r != 4'h0) begin
                lat_r <= lat_r - 4'h1;
            end
            if (step) begin
                beat_r <= beat1;
                left_r <= left_r - 4'h1;
            end
            if (last) begin
                bur_rd_r <= 1'b0;
                bur_wr_r <= 1'b0;
            end
        end
    end
    assign READ_ACTIVE = bur_rd_r;
    assign WRITE_ACTIVE = bur_wr_r;

    // ------------------------------------------------------------
    // Banks
    // ------------------------------------------------------------
    for (genvar b = 0; b < NBANK; b++) begin : g_bank
        logic open_q;
        logic [ROW_W-1:0] row_q;
        wire hit = cmd_r.ba == 2'(b);
        wire close = (is_pre && (hit || cmd_r.a[AP_BIT])) ||
            (ap_fire && bur_ba_r == 2'(b));
        always_ff @(posedge REF_CLK) begin
            if (!RST_N) begin
                open_q <= 1'b0;
                row_q <= '0;
            end else if (is_act && hit) begin
                open_q <= 1'b1; // R11
                row_q <= cmd_r.a[ROW_W-1:0]; // R7
            end else if (close) begin
                open_q <= 1'b0; // R10 R11
            end
        end
        assign BANK_OPEN[b] = open_q;
        assign row_lsb[b] = row_q[ROW_IDX-1:0];
    end

    // ------------------------------------------------------------
    // Array and data path
    // ------------------------------------------------------------
    logic [DW-1:0] mem [MEM_N];
    logic [DW-1:0] pair_hi_r;

    always_ff @(posedge REF_CLK) begin
        if (wr_go) begin
            for (int l = 0; l < DW / 8; l++) begin
                if (!lnk_r.dm[l]) begin
                    mem[idx0][8*l+:8] <= lnk_r.dq[8*l+:8]; // R3
                end
            end
        end
    end

    // Even beats fetch both words of the pair at once
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            DQ_O <= '0;
            DQ_OE <= 1'b0;
            DQS_O <= 1'b0;
            DQS_OE <= 1'b0;
            pair_hi_r <= '0;
        end else if (beat_go) begin
            DQ_O <= beat_r[0] ? pair_hi_r : mem[idx0]; // R5
            if (!beat_r[0]) pair_hi_r <= mem[idx1]; // R5
            DQS_O <= ~beat_r[0]; // R3 R4
            DQ_OE <= 1'b1;
            DQS_OE <= 1'b1; // R4
        end else if (ck_edge) begin
            DQ_OE <= 1'b0;
            DQS_OE <= 1'b0; // R4
            DQS_O <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Presence detect
    // ------------------------------------------------------------
    dmc_spd u_spd (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .scl(SPD_SCL),
        .sda_i(SPD_SDA_I),
        .sda_o(SPD_SDA_O),
        .sda_oe(SPD_SDA_OE),
        .straps(SPD_SLAVE_ADDRESS_STRAPS),
        .maker_we(SPD_MAKER_WE)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    chk_mode_load: assert property (is_mrs |=> // R12
        MODE_REG == $past(cmd_r.a))
        else $error("Mode register not loaded");
    chk_dll_selfclear: assert property ( // R13
        MODE_REG[MR_DLL_BIT] && !is_mrs |=> !MODE_REG[MR_DLL_BIT])
        else $error("Bit A8 did not clear");
    chk_cs_mask: assert property (ck_rise && cmd_r.cs_n && !ap_fire |=> // R21
        $stable(MODE_REG) && $stable(BANK_OPEN))
        else $error("Deselected command acted");
    chk_act_open: assert property (is_act |=> // R11
        BANK_OPEN[$past(cmd_r.ba)])
        else $error("Activate did not open bank");
    chk_ap_close: assert property (ap_fire && !is_act |=> // R10
        !BANK_OPEN[$past(bur_ba_r)])
        else $error("Auto precharge left bank open");
    chk_burst_wrap: assert property ( // R24
        (bur_rd_r || bur_wr_r) |-> (lo0 & ~bur_msk_r) ==
        (bur_col_r[2:0] & ~bur_msk_r))
        else $error("Burst left its block");
    chk_strobe_beat: assert property (beat_go |=> // R4
        DQ_OE && DQS_OE && DQS_O == !$past(beat_r[0]))
        else $error("Strobe not aligned with beat");
    chk_oe_quiet: assert property ( // R4
        !READ_ACTIVE && !DQ_OE |=> !DQ_OE && !DQS_OE)
        else $error("Strobe driven outside read");
    chk_rd_length: assert property ( // R9
        is_rd && bl_code == BL2 && !cmd_r.a[AP_BIT] |=>
        left_r == 4'h2)
        else $error("Burst length not taken");

    cov_mode_load: cover property (is_mrs);
    cov_read_cl25: cover property (beat_go && cl_code == CL25);
    cov_write_beat: cover property (wr_go ##1 !WRITE_ACTIVE);
    cov_auto_pre: cover property (ap_fire);
endmodule // dmc_top
`default_nettype wire
